// [tb/paf_periph_model.sv]
// ------------------------------------------------
// timer and analog module seen from the pins
// ------------------------------------------------
module paf_periph_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cmp_en_req,
  input wire logic i_cmp_wave_req,
  input wire logic [7:0] i_ana_req,
  input wire logic [7:0] i_ana_oe_req,
  input wire logic i_ext_clock,
  output logic o_cmp_en,
  output logic o_cmp_wave,
  output logic [7:0] o_ana,
  output logic [7:0] o_ana_oe,
  output logic [7:0] o_ext_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] sync;
  // each module makes its own override signals, one clock after the request
  always_ff @(posedge i_clk) begin
    o_cmp_en <= i_cmp_en_req;
    o_cmp_wave <= i_cmp_wave_req;
    o_ana_oe <= i_ana_oe_req;
    // released lanes show the inverse of the last value, never a stale copy
    if (i_srst) begin
      o_ana <= 8'h00;
    end else begin
      o_ana <= (i_ana_req & i_ana_oe_req) | (~o_ana & ~i_ana_oe_req);
    end
  end
  // the tap arrives unsynchronized, so the counter synchronizes it itself
  always_ff @(posedge i_clk) begin
    sync <= {sync[0], i_ext_clock};
    if (i_srst) begin
      o_ext_count <= 8'h00;
    end else if (sync == 2'b01) begin
      o_ext_count <= o_ext_count + 8'h01;
    end
  end
endmodule // paf_periph_model

// [tb/port_alternate_function_override_test.sv]
`include "paf_defs.svh"
module port_alternate_function_override_test import paf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] sel, port, pull, grp, mask, ana, pad;
    logic [2:0] ctl;
    logic [7:0] oe, out, pu, tap;
  } paf_row_s;
  // ctl holds sleep, compare-b enable, compare-b wave
  paf_row_s rows [6] = '{
    '{8'h00, 8'hFF, 8'h0F, 8'h00, 8'hFF, 8'h00, 8'hA5, 3'h0, 8'h00, 8'h00, 8'h0F, 8'hA5},
    '{8'hFF, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 3'h4, 8'hFF, 8'hA5, 8'h00, 8'h00},
    '{8'h20, 8'h00, 8'h00, 8'h01, 8'h0F, 8'hF0, 8'hFF, 3'h7, 8'h20, 8'h20, 8'h00, 8'h0F},
    '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h0C, 8'hFF, 3'h3, 8'h00, 8'h00, 8'h00, 8'hF3},
    '{8'h20, 8'h20, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h5A, 3'h2, 8'h20, 8'h00, 8'h00, 8'h5A},
    '{8'hF0, 8'h3C, 8'hC3, 8'h01, 8'h81, 8'h00, 8'h83, 3'h5, 8'hF0, 8'h30, 8'hC3, 8'h81}};
  logic clk = 1'b0, srst = 1'b1, sleep = 1'b0, cen_q = 1'b0, cwave_q = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] pad = 8'h00, aline = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [7:0] ana_q = 8'h00, ana_oe_q = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic cen, cwave, awready, wready, bvalid, arready, rvalid, t0, cpos, cneg;
  logic [7:0] oe, pout, pull, tap, pcs, conv, ana, ana_oe, ana_d, ana_oe_d, cnt, c0;
  int err_total = 0, compares = 0;

  paf_top paf_top_inst (
    .I_SYS_CLK(clk), .I_SRST(srst), .I_SLEEP(sleep), .I_PAD_IN(pad),
    .I_PAD_ANALOG_LINE(aline), .I_MOD_ANALOG_OUT(ana_d), .I_MOD_ANALOG_OE(ana_oe_d),
    .I_COMPARE_B_OUT_ENABLE(cen), .I_TIMER_ZERO_COMPARE_B_OUT(cwave),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
    .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
    .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .O_PAD_OUT(pout), .O_PAD_OE(oe), .O_PAD_PULL(pull), .O_PAD_ANALOG_OUT(ana),
    .O_PAD_ANALOG_OE(ana_oe), .O_RAW_INPUT_TAP(tap), .O_CONVERTER_CHANNEL(conv),
    .O_PIN_CHANGE_SOURCE(pcs), .O_COMPARATOR_POSITIVE_IN(cpos),
    .O_COMPARATOR_NEGATIVE_IN(cneg), .O_TIMER_ZERO_EXT_CLOCK(t0));
  paf_periph_model paf_periph_model_inst (
    .i_clk(clk), .i_srst(srst), .i_cmp_en_req(cen_q), .i_cmp_wave_req(cwave_q),
    .i_ana_req(ana_q), .i_ana_oe_req(ana_oe_q), .i_ext_clock(t0), .o_cmp_en(cen),
    .o_cmp_wave(cwave), .o_ana(ana_d), .o_ana_oe(ana_oe_d), .o_ext_count(cnt));

  initial begin
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------
  // checks, verdict and bus cycles
  // ------------------------------------------------
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
    chk({6'h00, got}, {6'h00, exp});
  endtask

  task automatic tmo(input int n);
    if (n >= 40) begin
      err_total++;
      $display("[FAIL] t=%0t wait=%h limit=%h", $time, n, 40);
      results();
    end
  endtask

  // every request is held until its own ready; the answer waits on a bounded loop
  task automatic wrchk(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                       input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {`PAF_ZERO_PAD, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    chkr(bresp, er);
    bready <= 1'b0;
    tmo(n);
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    chk(rdata[7:0], e);
    chk(rdata[15:8], 8'h00);
    chkr(rresp, er);
    rready <= 1'b0;
    tmo(n);
    @(posedge clk);
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    paf_row_s r;
    logic [7:0] offs [6];
    logic [47:0] v;
    offs = '{`PAF_OFF_PORT_OUT, `PAF_OFF_OUT_SEL, `PAF_OFF_PULL_SEL, `PAF_OFF_PC_GROUP,
             `PAF_OFF_PC_MASK, `PAF_OFF_ANA_OFF};
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(oe, 8'h00);
    chk({pout[7:1], bvalid}, 8'h00);
    $display("reset test done, mismatches %0d", err_total);
    foreach (rows[i]) begin
      r = rows[i];
      v = {r.port, r.sel, r.pull, r.grp, r.mask, r.ana};
      for (int k = 0; k < 6; k++) wrchk(offs[k], v[47-8*k -: 8], 4'hF, PAF_RESP_OKAY);
      sleep <= r.ctl[2];
      cen_q <= r.ctl[1];
      cwave_q <= r.ctl[0];
      pad <= r.pad;
      aline <= ~r.pad;
      repeat (3) @(posedge clk);
      #1;
      chk(oe, r.oe);
      chk(pout, r.out);
      chk(pull, r.pu);
      chk(tap, r.tap);
      chk(pcs, r.tap);
      chk({7'h00, t0}, {7'h00, r.tap[4]});
      chk(conv, ~r.pad);
      chk({6'h00, cneg, cpos}, {6'h00, ~r.pad[2:1]});
      @(posedge clk);
      rdchk(`PAF_OFF_PIN_IN, r.tap, PAF_RESP_OKAY);
      rdchk(`PAF_OFF_OUT_SEL, r.sel, PAF_RESP_OKAY);
      $display("row %0d done, mismatches %0d", i, err_total);
    end
    // unmapped place, masked strobe, toggle of single port bits
    wrchk(8'h1C, 8'hFF, 4'hF, PAF_RESP_SLVERR);
    rdchk(8'h1C, 8'h00, PAF_RESP_SLVERR);
    wrchk(`PAF_OFF_OUT_SEL, 8'h00, 4'hF, PAF_RESP_OKAY);
    wrchk(`PAF_OFF_OUT_SEL, 8'hFF, 4'hE, PAF_RESP_OKAY);
    rdchk(`PAF_OFF_OUT_SEL, 8'h00, PAF_RESP_OKAY);
    wrchk(`PAF_OFF_PORT_OUT, 8'hA5, 4'hF, PAF_RESP_OKAY);
    wrchk(`PAF_OFF_PIN_IN, 8'h0F, 4'hF, PAF_RESP_OKAY);
    rdchk(`PAF_OFF_PORT_OUT, 8'hAA, PAF_RESP_OKAY);
    $display("register test done, mismatches %0d", err_total);
    // the tap clocks the timer through its own synchronizer
    sleep <= 1'b0;
    c0 = cnt;
    repeat (3) begin
      pad[4] <= 1'b1;
      repeat (4) @(posedge clk);
      pad[4] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    chk(cnt, c0 + 8'h03);
    ana_q <= 8'h3C;
    ana_oe_q <= 8'h0F;
    repeat (2) @(posedge clk);
    #1;
    chk(ana & 8'h0F, 8'h0C);
    chk(ana_oe, 8'h0F);
    $display("alternate input test done, mismatches %0d", err_total);
    // reset in mid-run must drop the driver enables
    @(posedge clk);
    wrchk(`PAF_OFF_OUT_SEL, 8'hFF, 4'hF, PAF_RESP_OKAY);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(oe, 8'h00);
    @(posedge clk);
    rdchk(`PAF_OFF_OUT_SEL, 8'h00, PAF_RESP_OKAY);
    $display("second reset test done, mismatches %0d", err_total);
    results();
  end
endmodule // port_alternate_function_override_test

// [verilog/paf_defs.svh]
`ifndef PAF_DEFS_SVH
`define PAF_DEFS_SVH

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define PAF_ADDR_W 8
`define PAF_OFF_PORT_OUT 8'h00
`define PAF_OFF_OUT_SEL 8'h04
`define PAF_OFF_PULL_SEL 8'h08
`define PAF_OFF_PIN_IN 8'h0C
`define PAF_OFF_PC_GROUP 8'h10
`define PAF_OFF_PC_MASK 8'h14
`define PAF_OFF_ANA_OFF 8'h18

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define PAF_RST_BYTE 8'h00
`define PAF_RST_BIT 1'b0
`define PAF_ZERO_PAD 24'h00_0000
`define PAF_GROUP0_EN_BIT 0
`define PAF_BYTE_LANE 0
`define PAF_BIT_CMP_POS 1
`define PAF_BIT_CMP_NEG 2
`define PAF_BIT_T0_CLK 4
`define PAF_BIT_CMP_B 5
`define PAF_NPINS 8

`endif

// [verilog/paf_pin.sv]
// ----------------------------------------------------------------
// one pin: override muxing of the pin controls
// ----------------------------------------------------------------
module paf_pin (
  input wire logic i_pull_sel,
  input wire logic i_out_sel,
  input wire logic i_port_out,
  input wire logic i_sleep,
  input wire logic i_pull_override_en,
  input wire logic i_pull_override_val,
  input wire logic i_drive_override_en,
  input wire logic i_drive_override_val,
  input wire logic i_level_override_en,
  input wire logic i_level_override_val,
  input wire logic i_input_gate_override_en,
  input wire logic i_input_gate_override_val,
  output logic o_pull,
  output logic o_drive,
  output logic o_level,
  output logic o_gate
);
  always_comb begin
    o_pull = i_pull_override_en ? i_pull_override_val : i_pull_sel;
    o_drive = i_drive_override_en ? i_drive_override_val : i_out_sel;
    // level only matters while driving; park low otherwise
    o_level = 1'b0;
    if (o_drive) begin
      o_level = i_level_override_en ? i_level_override_val : i_port_out;
    end
    o_gate = i_input_gate_override_en ? i_input_gate_override_val : !i_sleep;
  end
endmodule // paf_pin

// [verilog/paf_pkg.sv]
package paf_pkg;
  typedef logic [7:0] paf_byte_t;
  typedef enum logic [1:0] {
    PAF_RESP_OKAY = 2'b00,
    PAF_RESP_SLVERR = 2'b10
  } paf_resp_e;
endpackage : paf_pkg

// [verilog/paf_top.sv]
// Summary of operation
// - pull-up follows override, else pull-up select bit
// - driver enable follows override, else output select
// - driven level from override value, else port bit
// - toggle override inverts the stored port bit
// - input gate follows override, else sleep state
// - raw tap before synchronizer; receiver synchronizes
// - analog line passes straight between pad, module
// - strobes shared per port, other controls per pin
// - bits feed converter channel and group-0 pin change
// - bit 1 comparator plus, bit 2 minus
// - bit 4 raw tap clocks timer zero
// - bit 5 carries compare-b, needs output select
// - gate override from mask, group enable, analog off
// - output select one means output, zero input
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`include "paf_defs.svh"
module paf_top
  import paf_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  input wire logic I_SLEEP,
  input wire logic [7:0] I_PAD_IN,
  input wire logic [7:0] I_PAD_ANALOG_LINE,
  input wire logic [7:0] I_MOD_ANALOG_OUT,
  input wire logic [7:0] I_MOD_ANALOG_OE,
  input wire logic I_COMPARE_B_OUT_ENABLE,
  input wire logic I_TIMER_ZERO_COMPARE_B_OUT,
  input wire logic [`PAF_ADDR_W-1:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [`PAF_ADDR_W-1:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  output logic [7:0] O_PAD_OUT,
  output logic [7:0] O_PAD_OE,
  output logic [7:0] O_PAD_PULL,
  output logic [7:0] O_PAD_ANALOG_OUT,
  output logic [7:0] O_PAD_ANALOG_OE,
  output logic [7:0] O_RAW_INPUT_TAP,
  output logic [7:0] O_CONVERTER_CHANNEL,
  output logic [7:0] O_PIN_CHANGE_SOURCE,
  output logic O_COMPARATOR_POSITIVE_IN,
  output logic O_COMPARATOR_NEGATIVE_IN,
  output logic O_TIMER_ZERO_EXT_CLOCK
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  paf_byte_t port_out, next_port_out;
  paf_byte_t out_sel, next_out_sel;
  paf_byte_t pull_sel, next_pull_sel;
  paf_byte_t pc_mask, next_pc_mask;
  paf_byte_t ana_off, next_ana_off;
  logic pc_group_en, next_pc_group_en;
  paf_byte_t sync1, sync2;
  paf_byte_t pad_out, pad_oe, pad_pull;
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [`PAF_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0] w_data, next_w_data;
  logic w_lane, next_w_lane;
  logic bvalid, next_bvalid;
  paf_resp_e bresp, next_bresp;
  logic rvalid, next_rvalid;
  paf_resp_e rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic wr_fire;

  // ----------------------------------------------------------------
  // override sources for port A
  // ----------------------------------------------------------------
  paf_byte_t pull_oe, pull_ov, drive_oe, drive_ov, level_oe, level_ov;
  paf_byte_t toggle_oe, gate_oe, gate_ov;
  paf_byte_t pin_pull, pin_drive, pin_level, pin_gate, raw_tap;

  always_comb begin
    pull_oe = `PAF_RST_BYTE;
    pull_ov = `PAF_RST_BYTE;
    drive_oe = `PAF_RST_BYTE;
    drive_ov = `PAF_RST_BYTE;
    level_oe = `PAF_RST_BYTE;
    level_ov = `PAF_RST_BYTE;
    toggle_oe = `PAF_RST_BYTE;
    level_oe[`PAF_BIT_CMP_B] = I_COMPARE_B_OUT_ENABLE;
    level_ov[`PAF_BIT_CMP_B] = I_TIMER_ZERO_COMPARE_B_OUT;
    gate_ov = pc_mask & {`PAF_NPINS{pc_group_en}};
    gate_oe = gate_ov | ana_off;
  end

  // per pin controls are private; sleep is common to every pin
  genvar gi;
  generate
    for (gi = 0; gi < `PAF_NPINS; gi++) begin : g_pin
      paf_pin u_pin (
        .i_pull_sel(pull_sel[gi]),
        .i_out_sel(out_sel[gi]),
        .i_port_out(port_out[gi]),
        .i_sleep(I_SLEEP),
        .i_pull_override_en(pull_oe[gi]),
        .i_pull_override_val(pull_ov[gi]),
        .i_drive_override_en(drive_oe[gi]),
        .i_drive_override_val(drive_ov[gi]),
        .i_level_override_en(level_oe[gi]),
        .i_level_override_val(level_ov[gi]),
        .i_input_gate_override_en(gate_oe[gi]),
        .i_input_gate_override_val(gate_ov[gi]),
        .o_pull(pin_pull[gi]),
        .o_drive(pin_drive[gi]),
        .o_level(pin_level[gi]),
        .o_gate(pin_gate[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // input path and alternate outputs
  // ----------------------------------------------------------------
  // the tap must not be registered: a clock source cannot afford a
  // synchronizer, so these outputs are combinational by intent
  always_comb begin
    raw_tap = I_PAD_IN & pin_gate;
    O_RAW_INPUT_TAP = raw_tap;
    O_PIN_CHANGE_SOURCE = raw_tap;
    O_TIMER_ZERO_EXT_CLOCK = raw_tap[`PAF_BIT_T0_CLK];
    O_CONVERTER_CHANNEL = I_PAD_ANALOG_LINE;
    O_COMPARATOR_POSITIVE_IN = I_PAD_ANALOG_LINE[`PAF_BIT_CMP_POS];
    O_COMPARATOR_NEGATIVE_IN = I_PAD_ANALOG_LINE[`PAF_BIT_CMP_NEG];
    O_PAD_ANALOG_OUT = I_MOD_ANALOG_OUT;
    O_PAD_ANALOG_OE = I_MOD_ANALOG_OE;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      sync1 <= `PAF_RST_BYTE;
      sync2 <= `PAF_RST_BYTE;
      pad_out <= `PAF_RST_BYTE;
      pad_oe <= `PAF_RST_BYTE;
      pad_pull <= `PAF_RST_BYTE;
    end else begin
      sync1 <= raw_tap;
      sync2 <= sync1;
      pad_out <= pin_level;
      pad_oe <= pin_drive;
      pad_pull <= pin_pull;
    end
  end

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [`PAF_ADDR_W-1:0] a);
    is_mapped = (a == `PAF_OFF_PORT_OUT) || (a == `PAF_OFF_OUT_SEL) ||
                (a == `PAF_OFF_PULL_SEL) || (a == `PAF_OFF_PIN_IN) ||
                (a == `PAF_OFF_PC_GROUP) || (a == `PAF_OFF_PC_MASK) ||
                (a == `PAF_OFF_ANA_OFF);
  endfunction

  assign wr_fire = aw_held && w_held && !bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane = w_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_port_out = port_out ^ toggle_oe;
    next_out_sel = out_sel;
    next_pull_sel = pull_sel;
    next_pc_mask = pc_mask;
    next_ana_off = ana_off;
    next_pc_group_en = pc_group_en;
    if (I_AXI_AWVALID && O_AXI_AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = I_AXI_AWADDR;
    end
    if (I_AXI_WVALID && O_AXI_WREADY) begin
      next_w_held = 1'b1;
      next_w_data = I_AXI_WDATA[7:0];
      next_w_lane = I_AXI_WSTRB[`PAF_BYTE_LANE];
    end
    if (bvalid && I_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_addr) ? PAF_RESP_OKAY : PAF_RESP_SLVERR;
      if (w_lane) begin
        unique case (aw_addr)
          `PAF_OFF_PORT_OUT: next_port_out = w_data;
          `PAF_OFF_OUT_SEL: next_out_sel = w_data;
          `PAF_OFF_PULL_SEL: next_pull_sel = w_data;
          `PAF_OFF_PIN_IN: next_port_out = port_out ^ toggle_oe ^ w_data;
          `PAF_OFF_PC_GROUP: next_pc_group_en = w_data[`PAF_GROUP0_EN_BIT];
          `PAF_OFF_PC_MASK: next_pc_mask = w_data;
          `PAF_OFF_ANA_OFF: next_ana_off = w_data;
          default: next_bresp = PAF_RESP_SLVERR;
        endcase
      end
    end
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (rvalid && I_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
    if (I_AXI_ARVALID && O_AXI_ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp = PAF_RESP_OKAY;
      unique case (I_AXI_ARADDR)
        `PAF_OFF_PORT_OUT: next_rdata = {`PAF_ZERO_PAD, port_out};
        `PAF_OFF_OUT_SEL: next_rdata = {`PAF_ZERO_PAD, out_sel};
        `PAF_OFF_PULL_SEL: next_rdata = {`PAF_ZERO_PAD, pull_sel};
        `PAF_OFF_PIN_IN: next_rdata = {`PAF_ZERO_PAD, sync2};
        `PAF_OFF_PC_GROUP: next_rdata = {`PAF_ZERO_PAD, 7'h00, pc_group_en};
        `PAF_OFF_PC_MASK: next_rdata = {`PAF_ZERO_PAD, pc_mask};
        `PAF_OFF_ANA_OFF: next_rdata = {`PAF_ZERO_PAD, ana_off};
        default: begin
          next_rdata = {`PAF_ZERO_PAD, `PAF_RST_BYTE};
          next_rresp = PAF_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      port_out <= `PAF_RST_BYTE;
      out_sel <= `PAF_RST_BYTE;
      pull_sel <= `PAF_RST_BYTE;
      pc_mask <= `PAF_RST_BYTE;
      ana_off <= `PAF_RST_BYTE;
      pc_group_en <= `PAF_RST_BIT;
      aw_held <= `PAF_RST_BIT;
      w_held <= `PAF_RST_BIT;
      aw_addr <= `PAF_OFF_PORT_OUT;
      w_data <= `PAF_RST_BYTE;
      w_lane <= `PAF_RST_BIT;
      bvalid <= `PAF_RST_BIT;
      bresp <= PAF_RESP_OKAY;
      rvalid <= `PAF_RST_BIT;
      rresp <= PAF_RESP_OKAY;
      rdata <= {`PAF_ZERO_PAD, `PAF_RST_BYTE};
      O_AXI_AWREADY <= `PAF_RST_BIT;
      O_AXI_WREADY <= `PAF_RST_BIT;
      O_AXI_ARREADY <= `PAF_RST_BIT;
    end else begin
      port_out <= next_port_out;
      out_sel <= next_out_sel;
      pull_sel <= next_pull_sel;
      pc_mask <= next_pc_mask;
      ana_off <= next_ana_off;
      pc_group_en <= next_pc_group_en;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane <= next_w_lane;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      // ready is granted a cycle ahead, so one write is held at a time
      O_AXI_AWREADY <= !next_aw_held && !next_bvalid;
      O_AXI_WREADY <= !next_w_held && !next_bvalid;
      O_AXI_ARREADY <= !next_rvalid;
    end
  end

  assign O_AXI_BVALID = bvalid;
  assign O_AXI_BRESP = bresp;
  assign O_AXI_RVALID = rvalid;
  assign O_AXI_RRESP = rresp;
  assign O_AXI_RDATA = rdata;
  assign O_PAD_OUT = pad_out;
  assign O_PAD_OE = pad_oe;
  assign O_PAD_PULL = pad_pull;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);

  // no attempt starts on the release edge: the registers there still show reset
  pull_follow_a: assert property (!I_SRST |=> O_PAD_PULL == $past(pull_sel))
    else $error("pull-up does not follow select bits");
  drive_follow_a: assert property (!I_SRST |=> O_PAD_OE == $past(out_sel))
    else $error("driver enable does not follow output select");
  level_cmpb_a: assert property (
    !I_SRST && out_sel[`PAF_BIT_CMP_B] && I_COMPARE_B_OUT_ENABLE |=>
    O_PAD_OUT[`PAF_BIT_CMP_B] == $past(I_TIMER_ZERO_COMPARE_B_OUT))
    else $error("compare-b wave not on pin");
  level_reg_a: assert property (
    !I_SRST && out_sel[0] |=> O_PAD_OUT[0] == $past(port_out[0]))
    else $error("driven level not from port bit");
  toggle_write_a: assert property (
    wr_fire && w_lane && aw_addr == `PAF_OFF_PIN_IN |=>
    port_out == ($past(port_out) ^ $past(w_data)))
    else $error("pin write did not toggle port bits");
  gate_sleep_a: assert property (
    I_SLEEP && !gate_oe[0] |-> !raw_tap[0])
    else $error("input not clamped in sleep");
  gate_group_a: assert property (
    pc_group_en && pc_mask[3] |-> raw_tap[3] == I_PAD_IN[3])
    else $error("pin-change pin input gated off");
  sync_delay_a: assert property (!I_SRST |-> ##2 sync2 == $past(raw_tap, 2))
    else $error("synchronizer delay wrong");
  write_resp_a: assert property (
    wr_fire |=> O_AXI_BVALID && !O_AXI_AWREADY && !O_AXI_WREADY)
    else $error("write response missing");
endmodule // paf_top
